// *** src/dcfm_pkg.sv ***
package dcfm_pkg;

    // storage geometry
    localparam int DCFM_DEPTH = 64;
    localparam int DCFM_WIDTH = 36;
    localparam int DCFM_PTR_W = 7;
    localparam logic [6:0] DCFM_DEPTH_CNT = 7'h40;

    // field positions inside a sampled port vector
    localparam int DCFM_F_MB = 36;
    localparam int DCFM_F_WRITE = 37;
    localparam int DCFM_F_EN = 38;
    localparam int DCFM_F_SEL_N = 39;
    localparam int DCFM_F_CLK = 40;
    localparam int DCFM_PV_W = 41;

    // four preset almost-flag offsets, picked by the offset selects
    localparam logic [5:0] DCFM_OFS_PRESET0 = 6'h10;
    localparam logic [5:0] DCFM_OFS_PRESET1 = 6'h0C;
    localparam logic [5:0] DCFM_OFS_PRESET2 = 6'h08;
    localparam logic [5:0] DCFM_OFS_PRESET3 = 6'h04;

    // register offsets
    localparam logic [3:0] DCFM_REG_CTRL = 4'h0;
    localparam logic [3:0] DCFM_REG_STAT = 4'h4;
    localparam logic [3:0] DCFM_REG_MASK = 4'h8;
    localparam logic [3:0] DCFM_REG_LEVEL = 4'hC;

    // control bits
    localparam int DCFM_CTRL_ODD = 0;
    localparam int DCFM_CTRL_GEN_A = 1;
    localparam int DCFM_CTRL_GEN_B = 2;

    // status event bits
    localparam int DCFM_EV_MAIL1 = 0;
    localparam int DCFM_EV_MAIL2 = 1;
    localparam int DCFM_EV_PERR_A = 2;
    localparam int DCFM_EV_PERR_B = 3;
    localparam int DCFM_EV_OVER = 4;
    localparam int DCFM_EV_UNDER = 5;

    // reset values
    localparam logic [2:0] DCFM_CTRL_RST = 3'h1;
    localparam logic [5:0] DCFM_MASK_RST = 6'h00;

    // gray to binary for crossed pointers
    function automatic logic [6:0] dcfm_g2b(input logic [6:0] g);
        logic [6:0] b;
        b[6] = g[6];
        for (int i = 5; i >= 0; i--)
        begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction : dcfm_g2b

endpackage : dcfm_pkg

// *** src/dcfm_parity.sv ***
`timescale 1ns/1ns
// per-lane parity: four lanes of eight data bits, parity bit on top of each
module dcfm_parity
    import dcfm_pkg::*;
(
    input wire logic [35:0] i_data, // word to check or regenerate
    input wire logic i_odd, // high selects odd parity
    output logic [35:0] o_data, // word with regenerated parity bits
    output logic o_err // high when any lane mismatches
);
    logic [3:0] lane_err;

    // one lane per byte; generated bit replaces the stored one
    for (genvar k = 0; k < 4; k++)
    begin : g_lane
        logic pbit;
        assign pbit = i_odd ? ~(^i_data[9 * k +: 8]) : (^i_data[9 * k +: 8]);
        assign o_data[9 * k +: 8] = i_data[9 * k +: 8];
        assign o_data[9 * k + 8] = pbit;
        assign lane_err[k] = pbit != i_data[9 * k + 8];
    end

    assign o_err = |lane_err;
endmodule : dcfm_parity

// *** src/dcfm_top.sv ***
`timescale 1ns/1ns
// Function
// (R1) 64 words of 36 bits, written on port A, read in order on port B.
// (R2) two 36-bit mailboxes, one per direction, bypassing the FIFO store.
// (R3) each mailbox has a flag showing unread new mail.
// (R4) transfers happen only on qualified rising port clock edges.
// (R5) port clocks may be asynchronous or coincident with each other.
// (R6) full and almost-full flags made in port A domain, two-stage synchronized.
// (R7) empty and almost-empty flags made in port B domain, two-stage synchronized.
// (R8) almost-empty low while stored count is at or below the offset.
// (R9) almost-full low while free count is at or below the offset.
// (R10) parity on incoming data checked passively, never blocking the transfer.
// (R11) selectable parity generation on data read out of each port.
// (R12) each port is a 36-bit bidirectional bus, driven by device on reads.
// (R13) counts come from gray-coded pointers crossed between port domains.
// (R14) full flag forced full at reset, clears on second port A edge.
// (R15) offset selects sampled at reset release load one of four presets.
// (R16) port A mail write sets flag, blocking writes until port B reads.
// (R17) outside party holds select low and enable high to transfer on A.
module dcfm_top
    import dcfm_pkg::*;
(
    input wire logic i_clk_sys, // system clock, 25 MHz
    input wire logic i_resetn, // asynchronous reset, active low
    input wire logic i_write_port_clock, // port A clock pin
    input wire logic i_port_a_select_n, // port A chip select, active low
    input wire logic i_port_a_enable, // port A enable
    input wire logic i_port_a_write, // high writes, low reads
    input wire logic i_port_a_mail, // high selects a mailbox
    input wire logic [35:0] i_a_data, // port A bus input
    output logic [35:0] o_a_data, // port A bus output
    output logic o_a_data_oe, // port A bus drive enable
    input wire logic i_read_port_clock, // port B clock pin
    input wire logic i_port_b_select_n, // port B chip select, active low
    input wire logic i_port_b_enable, // port B enable
    input wire logic i_port_b_write, // high writes, low reads
    input wire logic i_port_b_mail, // high selects a mailbox
    input wire logic [35:0] i_b_data, // port B bus input
    output logic [35:0] o_b_data, // port B bus output
    output logic o_b_data_oe, // port B bus drive enable
    input wire logic i_offset_select_lo, // offset select, low bit
    input wire logic i_offset_select_hi, // offset select, high bit
    output logic o_full_flag_n, // low when FIFO full
    output logic o_almost_full_flag_n, // low when nearly full
    output logic o_empty_flag_n, // low when FIFO empty
    output logic o_almost_empty_flag_n, // low when nearly empty
    output logic o_a_to_b_mail_flag_n, // low while mail for port B waits
    output logic o_b_to_a_mail_flag_n, // low while mail for port A waits
    output logic o_a_parity_err_n, // low after bad parity on port A input
    output logic o_b_parity_err_n, // low after bad parity on port B input
    input wire logic [3:0] i_reg_addr, // register address
    input wire logic [31:0] i_reg_wdata, // register write data
    input wire logic i_reg_wr, // register write strobe
    input wire logic i_reg_rd, // register read strobe
    output logic [31:0] o_reg_rdata, // read data, cycle after strobe
    output logic o_irq // level interrupt
);
    typedef struct packed {
        logic [40:0] a_s1;
        logic [40:0] a_s2;
        logic a_clk3;
        logic [40:0] b_s1;
        logic [40:0] b_s2;
        logic b_clk3;
        logic [1:0] fs_s1;
        logic [1:0] fs_s2;
        logic [1:0] fs_done;
        logic [5:0] offset;
        logic [63:0][35:0] mem;
        logic [6:0] wr_bin;
        logic [6:0] wr_gray;
        logic [6:0] rd_bin;
        logic [6:0] rd_gray;
        logic [6:0] rdg_a1;
        logic [6:0] rdg_a2;
        logic [6:0] wrg_b1;
        logic [6:0] wrg_b2;
        logic a_live;
        logic b_live;
        logic full_n;
        logic afull_n;
        logic empty_n;
        logic aempty_n;
        logic [35:0] mail1;
        logic [35:0] mail2;
        logic a_to_b_mail_flag_n_n;
        logic mbf2_n;
        logic [35:0] a_dout;
        logic [35:0] b_dout;
        logic a_oe;
        logic b_oe;
        logic a_perr_n;
        logic b_perr_n;
        logic [2:0] ctrl;
        logic [5:0] stat;
        logic [5:0] mask;
        logic [31:0] rdata;
        logic irq;
    } dcfm_state_type;

    localparam dcfm_state_type ST_RST = '{
        offset: DCFM_OFS_PRESET0,
        a_to_b_mail_flag_n_n: 1'b1,
        mbf2_n: 1'b1,
        a_perr_n: 1'b1,
        b_perr_n: 1'b1,
        ctrl: DCFM_CTRL_RST,
        mask: DCFM_MASK_RST,
        default: '0
    };

    dcfm_state_type q;
    dcfm_state_type d;
    logic [1:0] rst_q;
    logic rst_n;
    logic [35:0] chk_a_unused;
    logic [35:0] chk_b_unused;
    logic [35:0] gen_a_data;
    logic [35:0] gen_b_data;
    logic perr_a;
    logic perr_b;
    logic a_edge;
    logic b_edge;
    logic a_xfer;
    logic b_xfer;
    logic a_wr_fifo;
    logic a_wr_mail;
    logic a_rd_mail;
    logic b_rd_fifo;
    logic b_rd_mail;
    logic b_wr_mail;
    logic [6:0] cnt_a;
    logic [6:0] cnt_b;
    logic [6:0] free_a;
    logic [5:0] ev;

    // reset is released through two flops so removal is clean
    always_ff @(posedge i_clk_sys or negedge i_resetn)
    begin
        if (!i_resetn)
            rst_q <= 2'h0;
        else
            rst_q <= {rst_q[0], 1'b1};
    end
    assign rst_n = rst_q[1];

    // parity units: check on incoming words, generate on outgoing ones
    dcfm_parity u_chk_a (
        .i_data(q.a_s2[35:0]),
        .i_odd(q.ctrl[DCFM_CTRL_ODD]),
        .o_data(chk_a_unused),
        .o_err(perr_a)
    );
    dcfm_parity u_chk_b (
        .i_data(q.b_s2[35:0]),
        .i_odd(q.ctrl[DCFM_CTRL_ODD]),
        .o_data(chk_b_unused),
        .o_err(perr_b)
    );
    dcfm_parity u_gen_a (
        .i_data(q.mail2),
        .i_odd(q.ctrl[DCFM_CTRL_ODD]),
        .o_data(gen_a_data),
        .o_err()
    );
    dcfm_parity u_gen_b (
        .i_data(b_rd_mail ? q.mail1 : q.mem[q.rd_bin[5:0]]),
        .i_odd(q.ctrl[DCFM_CTRL_ODD]),
        .o_data(gen_b_data),
        .o_err()
    );

    // edges come from the second sync stage against a third; the pins
    // share the same depth so data lines up with its clock edge
    assign a_edge = q.a_s2[DCFM_F_CLK] & ~q.a_clk3; // see (R4) (R5)
    assign b_edge = q.b_s2[DCFM_F_CLK] & ~q.b_clk3; // see (R4) (R5)
    assign a_xfer = a_edge & ~q.a_s2[DCFM_F_SEL_N] & q.a_s2[DCFM_F_EN]; // see (R4) (R17)
    assign b_xfer = b_edge & ~q.b_s2[DCFM_F_SEL_N] & q.b_s2[DCFM_F_EN]; // see (R4)
    assign a_wr_fifo = a_xfer & q.a_s2[DCFM_F_WRITE] & ~q.a_s2[DCFM_F_MB] & q.full_n;
    assign a_wr_mail = a_xfer & q.a_s2[DCFM_F_WRITE] & q.a_s2[DCFM_F_MB] & q.a_to_b_mail_flag_n_n; // see (R16)
    assign a_rd_mail = a_xfer & ~q.a_s2[DCFM_F_WRITE] & q.a_s2[DCFM_F_MB];
    assign b_rd_fifo = b_xfer & ~q.b_s2[DCFM_F_WRITE] & ~q.b_s2[DCFM_F_MB] & q.empty_n;
    assign b_rd_mail = b_xfer & ~q.b_s2[DCFM_F_WRITE] & q.b_s2[DCFM_F_MB];
    assign b_wr_mail = b_xfer & q.b_s2[DCFM_F_WRITE] & q.b_s2[DCFM_F_MB] & q.mbf2_n;

    // counts use the next own pointer against the synced far pointer, so a
    // flag never lags its own side's transfer and over/underrun is impossible
    assign cnt_a = 7'(q.wr_bin + {6'h00, a_wr_fifo} - dcfm_g2b(q.rdg_a2)); // see (R13)
    assign cnt_b = 7'(dcfm_g2b(q.wrg_b2) - q.rd_bin - {6'h00, b_rd_fifo}); // see (R13)
    assign free_a = 7'(DCFM_DEPTH_CNT - cnt_a);

    // events that reach the status register
    always_comb
    begin
        ev = 6'h00;
        ev[DCFM_EV_MAIL1] = a_wr_mail;
        ev[DCFM_EV_MAIL2] = b_wr_mail;
        ev[DCFM_EV_PERR_A] = a_xfer & q.a_s2[DCFM_F_WRITE] & perr_a;
        ev[DCFM_EV_PERR_B] = b_xfer & q.b_s2[DCFM_F_WRITE] & perr_b;
        ev[DCFM_EV_OVER] = a_xfer & q.a_s2[DCFM_F_WRITE] & ~q.a_s2[DCFM_F_MB] & ~q.full_n;
        ev[DCFM_EV_UNDER] = b_xfer & ~q.b_s2[DCFM_F_WRITE] & ~q.b_s2[DCFM_F_MB] & ~q.empty_n;
    end

    // next state of the whole block
    always_comb
    begin
        d = q;
        // port and offset pins pass two flops before any logic reads them
        d.a_s1 = {i_write_port_clock, i_port_a_select_n, i_port_a_enable, i_port_a_write,
                  i_port_a_mail, i_a_data};
        d.a_s2 = q.a_s1;
        d.a_clk3 = q.a_s2[DCFM_F_CLK];
        d.b_s1 = {i_read_port_clock, i_port_b_select_n, i_port_b_enable, i_port_b_write,
                  i_port_b_mail, i_b_data};
        d.b_s2 = q.b_s1;
        d.b_clk3 = q.b_s2[DCFM_F_CLK];
        d.fs_s1 = {i_offset_select_hi, i_offset_select_lo};
        d.fs_s2 = q.fs_s1;

        // reloaded for three cycles so the last load sees both sync stages
        if (q.fs_done != 2'h3)
        begin
            d.fs_done = 2'(q.fs_done + 2'h1);
            case (q.fs_s2) // see (R15)
                2'h0: d.offset = DCFM_OFS_PRESET0;
                2'h1: d.offset = DCFM_OFS_PRESET1;
                2'h2: d.offset = DCFM_OFS_PRESET2;
                default: d.offset = DCFM_OFS_PRESET3;
            endcase
        end

        // port A side: store write, mailbox traffic, flag synchronizer
        if (a_wr_fifo)
        begin
            d.mem[q.wr_bin[5:0]] = q.a_s2[35:0]; // see (R1)
            d.wr_bin = 7'(q.wr_bin + 7'h01);
        end
        d.wr_gray = d.wr_bin ^ (d.wr_bin >> 1); // see (R13)
        if (a_wr_mail)
            d.mail1 = q.a_s2[35:0]; // see (R2)
        if (a_edge)
        begin
            d.rdg_a1 = q.rd_gray; // see (R6)
            d.rdg_a2 = q.rdg_a1;
            d.a_live = 1'b1;
            // held full through the first edge, so it clears on the second
            d.full_n = q.a_live & (cnt_a != DCFM_DEPTH_CNT); // see (R6) (R14)
            d.afull_n = q.a_live & (free_a > {1'b0, q.offset}); // see (R9)
            d.a_oe = ~q.a_s2[DCFM_F_SEL_N] & ~q.a_s2[DCFM_F_WRITE]; // see (R12)
        end
        if (a_xfer & q.a_s2[DCFM_F_WRITE])
            d.a_perr_n = ~perr_a; // see (R10)
        if (a_rd_mail)
            d.a_dout = q.ctrl[DCFM_CTRL_GEN_A] ? gen_a_data : q.mail2; // see (R11)

        // port B side
        if (b_rd_fifo)
        begin
            d.b_dout = q.ctrl[DCFM_CTRL_GEN_B] ? gen_b_data : q.mem[q.rd_bin[5:0]]; // see (R1) (R11)
            d.rd_bin = 7'(q.rd_bin + 7'h01);
        end
        if (b_rd_mail)
            d.b_dout = q.ctrl[DCFM_CTRL_GEN_B] ? gen_b_data : q.mail1;
        d.rd_gray = d.rd_bin ^ (d.rd_bin >> 1); // see (R13)
        if (b_wr_mail)
            d.mail2 = q.b_s2[35:0]; // see (R2)
        if (b_edge)
        begin
            d.wrg_b1 = q.wr_gray; // see (R7)
            d.wrg_b2 = q.wrg_b1;
            d.b_live = 1'b1;
            d.empty_n = q.b_live & (cnt_b != 7'h00); // see (R7)
            d.aempty_n = q.b_live & (cnt_b > {1'b0, q.offset}); // see (R8)
            d.b_oe = ~q.b_s2[DCFM_F_SEL_N] & ~q.b_s2[DCFM_F_WRITE]; // see (R12)
        end
        if (b_xfer & q.b_s2[DCFM_F_WRITE])
            d.b_perr_n = ~perr_b; // see (R10)

        // mail flags: a new write wins over a read in the same cycle
        if (b_rd_mail)
            d.a_to_b_mail_flag_n_n = 1'b1;
        if (a_wr_mail)
            d.a_to_b_mail_flag_n_n = 1'b0; // see (R3) (R16)
        if (a_rd_mail)
            d.mbf2_n = 1'b1;
        if (b_wr_mail)
            d.mbf2_n = 1'b0; // see (R3)

        // register writes; status clears by writing ones, events win
        d.stat = q.stat | ev;
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                DCFM_REG_CTRL: d.ctrl = i_reg_wdata[2:0];
                DCFM_REG_STAT: d.stat = (q.stat & ~i_reg_wdata[5:0]) | ev;
                DCFM_REG_MASK: d.mask = i_reg_wdata[5:0];
                default: d.ctrl = q.ctrl;
            endcase
        end
        d.irq = |(d.stat & d.mask);

        // read data stands only in the cycle after the strobe
        d.rdata = 32'h00000000;
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                DCFM_REG_CTRL: d.rdata = {29'h00000000, q.ctrl};
                DCFM_REG_STAT: d.rdata = {26'h0000000, q.stat};
                DCFM_REG_MASK: d.rdata = {26'h0000000, q.mask};
                DCFM_REG_LEVEL: d.rdata = {4'h0, q.mbf2_n, q.a_to_b_mail_flag_n_n, q.aempty_n, q.empty_n,
                                           q.afull_n, q.full_n, q.offset, 1'b0, q.rd_bin, 1'b0, q.wr_bin};
                default: d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            q <= ST_RST;
        else
            q <= d;
    end

    assign o_a_data = q.a_dout;
    assign o_a_data_oe = q.a_oe;
    assign o_b_data = q.b_dout;
    assign o_b_data_oe = q.b_oe;
    assign o_full_flag_n = q.full_n;
    assign o_almost_full_flag_n = q.afull_n;
    assign o_empty_flag_n = q.empty_n;
    assign o_almost_empty_flag_n = q.aempty_n;
    assign o_a_to_b_mail_flag_n = q.a_to_b_mail_flag_n_n;
    assign o_b_to_a_mail_flag_n = q.mbf2_n;
    assign o_a_parity_err_n = q.a_perr_n;
    assign o_b_parity_err_n = q.b_perr_n;
    assign o_reg_rdata = q.rdata;
    assign o_irq = q.irq;

    // checks on the block's own behaviour
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_n);

    store_order_a: assert property (b_rd_fifo && !q.ctrl[DCFM_CTRL_GEN_B] // see (R1)
        |=> o_b_data == $past(q.mem[q.rd_bin[5:0]]))
        else $error("fifo word out of order");
    mail_hold_a: assert property ((a_xfer && q.a_s2[DCFM_F_WRITE] && q.a_s2[DCFM_F_MB] && !q.a_to_b_mail_flag_n_n) // see (R16)
        |=> $stable(q.mail1))
        else $error("mailbox overwritten while flagged");
    mail_flag_a: assert property (a_wr_mail |=> !o_a_to_b_mail_flag_n) // see (R3)
        else $error("mail flag not set by write");
    no_edge_a: assert property (!a_edge |=> $stable(q.wr_bin)) // see (R4)
        else $error("store written without port edge");
    full_true_a: assert property (cnt_a == DCFM_DEPTH_CNT && a_edge |=> !o_full_flag_n) // see (R6)
        else $error("full flag missed");
    empty_true_a: assert property (o_empty_flag_n |-> q.wr_bin != q.rd_bin) // see (R7)
        else $error("empty flag high with nothing stored");
    full_reset_a: assert property (!q.a_live |=> !o_full_flag_n) // see (R14)
        else $error("full flag released early");
    almost_empty_a: assert property (b_edge && q.b_live // see (R8)
        |=> o_almost_empty_flag_n == ($past(cnt_b) > {1'b0, $past(q.offset)}))
        else $error("almost empty flag wrong");
    almost_full_a: assert property (a_edge && q.a_live // see (R9)
        |=> o_almost_full_flag_n == ($past(free_a) > {1'b0, $past(q.offset)}))
        else $error("almost full flag wrong");
    bus_drive_a: assert property (a_edge && !q.a_s2[DCFM_F_SEL_N] && !q.a_s2[DCFM_F_WRITE] // see (R12)
        |=> o_a_data_oe [*1] ##0 !o_a_data_oe == 1'b0)
        else $error("port A bus not driven on read");

endmodule : dcfm_top

// *** testbench/dcfm_host_model.sv ***
`timescale 1ns/1ns
// bus masters at both ports; index 0 is port A, index 1 is port B
module dcfm_host_model
(
    input wire logic i_clk_sys, // system clock
    input wire logic [35:0] i_a_dout, // device drive on A
    input wire logic i_a_oe, // device drives A
    input wire logic [35:0] i_b_dout, // device drive on B
    input wire logic i_b_oe, // device drives B
    output logic [1:0] o_pclk, // port clocks
    output logic [1:0] o_sel_n, // chip selects, active low
    output logic [1:0] o_en, // port enables
    output logic [1:0] o_wr, // write selects
    output logic [1:0] o_mb, // mailbox selects
    output logic [35:0] o_a_bus, // resolved A bus level
    output logic [35:0] o_b_bus // resolved B bus level
);
    logic [35:0] drv_a = 36'h0;
    logic [35:0] drv_b = 36'h0;
    int cnt_a = 0;
    int cnt_b = 0;

    initial
    begin
        o_pclk = 2'h0;
        o_sel_n = 2'h3;
        o_en = 2'h0;
        o_wr = 2'h0;
        o_mb = 2'h0;
    end

    // free-running port clocks; unequal periods keep the two ports unrelated
    always @(posedge i_clk_sys)
    begin
        cnt_a <= (cnt_a == 4) ? 0 : cnt_a + 1;
        cnt_b <= (cnt_b == 5) ? 0 : cnt_b + 1;
        if (cnt_a == 4) o_pclk[0] <= ~o_pclk[0];
        if (cnt_b == 5) o_pclk[1] <= ~o_pclk[1];
    end

    // an idle master shows the inverse of its last word, never a stale copy
    assign o_a_bus = i_a_oe ? i_a_dout : drv_a;
    assign o_b_bus = i_b_oe ? i_b_dout : drv_b;

    // one transfer: set up after an edge, held through the taking edge
    task automatic xfer(input int p, input logic wr, input logic mb, input logic [35:0] d,
                        output logic [35:0] q);
        @(posedge o_pclk[p]);
        @(posedge i_clk_sys);
        o_sel_n[p] <= 1'b0;
        o_en[p] <= 1'b1;
        o_wr[p] <= wr;
        o_mb[p] <= mb;
        if (p == 0) drv_a <= d;
        else drv_b <= d;
        @(posedge o_pclk[p]);
        @(posedge i_clk_sys);
        o_sel_n[p] <= 1'b1;
        o_en[p] <= 1'b0;
        if (p == 0) drv_a <= ~d;
        else drv_b <= ~d;
        // read data has landed by the following port edge
        @(posedge o_pclk[p]);
        q = (p == 0) ? o_a_bus : o_b_bus;
    endtask : xfer
endmodule : dcfm_host_model

// *** testbench/dcfm_top_tb.sv ***
`timescale 1ns/1ns
module dcfm_top_tb
    import dcfm_pkg::*;
;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic offset_lo = 1'b0;
    logic offset_hi = 1'b1;
    logic [3:0] i_reg_addr = 4'h0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [1:0] pclk, sel_n, en, wr, mb;
    logic [35:0] a_bus, b_bus, a_dout, b_dout, q;
    logic a_oe, b_oe, full_n, afull_n, empty_n, aempty_n, mail1_n, mail2_n, perr_a_n, perr_b_n, irq;
    logic [31:0] rdata, r;
    int err_total = 0;
    int total_checks = 0;
    wire logic [3:0] flg = {full_n, afull_n, aempty_n, empty_n};

    initial
    begin
        forever #20 i_clk_sys = ~i_clk_sys;
    end

    dcfm_host_model host (.i_clk_sys(i_clk_sys), .i_a_dout(a_dout), .i_a_oe(a_oe), .i_b_dout(b_dout),
        .i_b_oe(b_oe), .o_pclk(pclk), .o_sel_n(sel_n), .o_en(en), .o_wr(wr), .o_mb(mb), .o_a_bus(a_bus),
        .o_b_bus(b_bus));

    dcfm_top uut (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_write_port_clock(pclk[0]),
        .i_port_a_select_n(sel_n[0]), .i_port_a_enable(en[0]), .i_port_a_write(wr[0]), .i_port_a_mail(mb[0]),
        .i_a_data(a_bus), .o_a_data(a_dout), .o_a_data_oe(a_oe), .i_read_port_clock(pclk[1]),
        .i_port_b_select_n(sel_n[1]), .i_port_b_enable(en[1]), .i_port_b_write(wr[1]), .i_port_b_mail(mb[1]),
        .i_b_data(b_bus), .o_b_data(b_dout), .o_b_data_oe(b_oe), .i_offset_select_lo(offset_lo),
        .i_offset_select_hi(offset_hi), .o_full_flag_n(full_n), .o_almost_full_flag_n(afull_n),
        .o_empty_flag_n(empty_n), .o_almost_empty_flag_n(aempty_n), .o_a_to_b_mail_flag_n(mail1_n),
        .o_b_to_a_mail_flag_n(mail2_n), .o_a_parity_err_n(perr_a_n), .o_b_parity_err_n(perr_b_n),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
        .o_reg_rdata(rdata), .o_irq(irq));

    task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge i_clk_sys);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clk_sys);
        i_reg_rd <= 1'b0;
        #1 d = rdata;
    endtask : reg_read

    // flags have no handshake; give both synchronizers several port edges
    task automatic settle;
        repeat (60) @(posedge i_clk_sys);
    endtask : settle

    // odd parity on each 9-bit lane
    function automatic logic [35:0] par(input logic [35:0] d);
        logic [35:0] v;
        v = d;
        for (int k = 0; k < 4; k++) v[9 * k + 8] = ~^d[9 * k +: 8];
        return v;
    endfunction : par

    function automatic logic [35:0] wd(input int i);
        return par(36'(i) * 36'h2_4689_1357 + 36'h1_0203_0405);
    endfunction : wd

    // main sequence
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        chk({32'h0, flg}, 36'h0);
        chk({33'h0, mail1_n, mail2_n, irq}, 36'h6);
        i_resetn <= 1'b1;
        settle();
        chk({32'h0, flg}, 36'hC);
        reg_read(DCFM_REG_CTRL, r);
        chk({4'h0, r}, 36'h1);
        reg_read(DCFM_REG_MASK, r);
        chk({4'h0, r}, 36'h0);
        reg_read(4'h2, r);
        chk({4'h0, r}, 36'h0);
        reg_write(DCFM_REG_MASK, 32'h3F);
        reg_read(DCFM_REG_MASK, r);
        chk({4'h0, r}, 36'h3F);
        // fill to the brim; preset offset 8 via selects {1,0}
        for (int i = 0; i < 64; i++)
        begin
            host.xfer(0, 1'b1, 1'b0, wd(i), q);
            if (i == 7 || i == 8 || i == 54 || i == 55 || i == 63)
            begin
                settle();
                chk({32'h0, flg}, {32'h0, i < 63, i < 55, i > 7, 1'b1});
            end
        end
        // refused word carries good parity so only the overrun bit rises
        host.xfer(0, 1'b1, 1'b0, wd(64), q);
        reg_read(DCFM_REG_STAT, r);
        chk({4'h0, r}, 36'h10);
        chk({35'h0, irq}, 36'h1);
        reg_write(DCFM_REG_STAT, 32'h10);
        reg_read(DCFM_REG_STAT, r);
        chk({4'h0, r}, 36'h0);
        // drain in order; the refused word must not show up
        for (int i = 0; i < 64; i++)
        begin
            host.xfer(1, 1'b0, 1'b0, 36'h0, q);
            chk(q, wd(i));
        end
        settle();
        chk({32'h0, flg}, 36'hC);
        host.xfer(1, 1'b0, 1'b0, 36'h0, q);
        reg_read(DCFM_REG_STAT, r);
        chk({4'h0, r}, 36'h20);
        // bad parity still stored; regenerated on the way out of B
        host.xfer(0, 1'b1, 1'b0, wd(0) ^ 36'h1, q);
        settle();
        chk({35'h0, perr_a_n}, 36'h0);
        reg_write(DCFM_REG_STAT, 32'h3F);
        reg_write(DCFM_REG_CTRL, 32'h5);
        host.xfer(1, 1'b0, 1'b0, 36'h0, q);
        chk(q, par(wd(0) ^ 36'h1));
        // mailbox A to B, second write blocked while unread
        host.xfer(0, 1'b1, 1'b1, wd(1), q);
        host.xfer(0, 1'b1, 1'b1, wd(2), q);
        settle();
        chk({35'h0, mail1_n}, 36'h0);
        host.xfer(1, 1'b0, 1'b1, 36'h0, q);
        chk(q, wd(1));
        settle();
        chk({35'h0, mail1_n}, 36'h1);
        // mailbox B to A with a bad parity bit, passed through raw
        host.xfer(1, 1'b1, 1'b1, wd(3) ^ 36'h100, q);
        settle();
        chk({34'h0, mail2_n, perr_b_n}, 36'h0);
        host.xfer(0, 1'b0, 1'b1, 36'h0, q);
        chk(q, wd(3) ^ 36'h100);
        settle();
        chk({35'h0, mail2_n}, 36'h1);
        reg_read(DCFM_REG_STAT, r);
        chk({4'h0, r}, 36'h0B);
        // interrupt follows the mask and the clear
        reg_write(DCFM_REG_MASK, 32'h0);
        repeat (3) @(posedge i_clk_sys);
        chk({35'h0, irq}, 36'h0);
        reg_write(DCFM_REG_MASK, 32'h2);
        repeat (3) @(posedge i_clk_sys);
        chk({35'h0, irq}, 36'h1);
        reg_write(DCFM_REG_STAT, 32'h2);
        repeat (3) @(posedge i_clk_sys);
        chk({35'h0, irq}, 36'h0);
        final_report();
    end

    // about 150 transfers of three port periods each need well under 300 us
    initial
    begin
        #1000000;
        err_total++;
        final_report();
    end
endmodule : dcfm_top_tb
